// [design/rhc_consts.vh]
// Purpose: constants for the ring setup command handler
// Assumes: 64-bit ring commands, six source rings, eight destination slots
// Notes:   register byte offsets are word aligned
`ifndef RHC_CONSTS_VH
`define RHC_CONSTS_VH
// register byte offsets
`define RHC_OFS_CMD_LO    8'h00
`define RHC_OFS_CMD_HI    8'h04
`define RHC_OFS_STATUS    8'h08
`define RHC_OFS_RML       8'h0C
`define RHC_OFS_LML       8'h10
`define RHC_OFS_STATE     8'h14
`define RHC_OFS_DEST      8'h18
`define RHC_OFS_SEL       8'h1C
`define RHC_OFS_RDPTR     8'h20
`define RHC_OFS_WRPTR     8'h24
`define RHC_OFS_LMADDR    8'h28
`define RHC_OFS_ENABLE    8'h2C
// status bits
`define RHC_ST_ERR        6
`define RHC_ST_BUSY       7
// command fields
`define RHC_F_TOP         63
`define RHC_F_IND         62
`define RHC_F_ONES_HI     61
`define RHC_F_ONES_LO     57
`define RHC_F_Z_HI        56
`define RHC_F_Z_LO        55
`define RHC_F_LOCAL       54
`define RHC_F_B53         53
`define RHC_F_B52         52
`define RHC_F_RDY         51
`define RHC_F_RING_HI     50
`define RHC_F_RING_LO     48
`define RHC_F_RDLO_HI     47
`define RHC_F_RDLO_LO     35
`define RHC_F_PHI_HI      31
`define RHC_F_PHI_LO      16
`define RHC_F_WRLO_HI     15
`define RHC_F_WRLO_LO     3
// command kinds
`define RHC_K_NONE        3'd0
`define RHC_K_DEST        3'd1
`define RHC_K_LMSA        3'd2
`define RHC_K_STOP        3'd3
`define RHC_K_DEFINE      3'd4
// local/indication settings
`define RHC_LI_NORMAL     2'b00
`define RHC_LI_INVALID    2'b01
`define RHC_LI_XFER       2'b11
// ring states
`define RHC_RS_NDEF       3'd0
`define RHC_RS_READY      3'd1
`define RHC_RS_CMPL       3'd2
`define RHC_RS_WAITF      3'd3
`define RHC_RS_WBACK      3'd4
`define RHC_RS_STOPPED    3'd5
// ring numbering
`define RHC_LAST_SRC      3'd5
`define RHC_LAST_TX       3'd3
// wrap bases: ring length 8 << code, local length 8K << code
`define RHC_RING_BASE     32'h0000_0008
`define RHC_LM_BASE       32'h0000_2000
`define RHC_STEP          32'h0000_0008
`endif

// [design/rhc_cmd_decode.v]
// Purpose: classify one 64-bit ring handling command and split its fields
// Assumes: command word is stable while examined
// Notes:   purely combinational
`timescale 1ns/1ps
`include "rhc_consts.vh"
module rhc_cmd_decode (
  input  wire [63:0] cmd,
  output reg  [2:0]  kind,
  output wire [2:0]  ring,
  output wire        rdy,
  output wire [1:0]  li,
  output wire [31:0] rd_ptr,
  output wire [31:0] wr_ptr
);
  wire pre;
  assign pre    = cmd[`RHC_F_TOP] & (&cmd[`RHC_F_ONES_HI:`RHC_F_ONES_LO])
                  & ~(|cmd[`RHC_F_Z_HI:`RHC_F_Z_LO]);
  assign ring   = cmd[`RHC_F_RING_HI:`RHC_F_RING_LO];
  assign rdy    = cmd[`RHC_F_RDY];
  assign li     = {cmd[`RHC_F_LOCAL], cmd[`RHC_F_IND]};
  // low three pointer bits forced to zero
  assign rd_ptr = {cmd[`RHC_F_PHI_HI:`RHC_F_PHI_LO],
                   cmd[`RHC_F_RDLO_HI:`RHC_F_RDLO_LO], 3'b000};
  assign wr_ptr = {cmd[`RHC_F_PHI_HI:`RHC_F_PHI_LO],
                   cmd[`RHC_F_WRLO_HI:`RHC_F_WRLO_LO], 3'b000};

  always @* begin
    kind = `RHC_K_NONE;
    if (pre & ~cmd[`RHC_F_LOCAL] & ~cmd[`RHC_F_B53] & cmd[`RHC_F_B52]) begin
      // shared pattern: rings 0-5 with ready set mean local start, anything else means destination
      if (cmd[`RHC_F_RDY] & (ring <= `RHC_LAST_SRC))
        kind = `RHC_K_LMSA;
      else
        kind = `RHC_K_DEST;
    end else if (pre & cmd[`RHC_F_B53] & ~cmd[`RHC_F_B52]) begin
      if (~cmd[`RHC_F_LOCAL] & ~cmd[`RHC_F_RDY])
        kind = `RHC_K_STOP;
      else
        kind = `RHC_K_DEFINE;
    end
  end
endmodule

// [design/rhc_ring_ctl.v]
// Purpose: state of one source ring: define, stop sequence, self stop
// Assumes: define_go only while ring is idle enough to redefine
// Notes:   one instance per source ring
`timescale 1ns/1ps
`include "rhc_consts.vh"
module rhc_ring_ctl (
  input  wire       hclk,
  input  wire       hresetn,
  input  wire       define_go,
  input  wire       def_ready,
  input  wire       stop_go,
  input  wire       self_stop,
  input  wire       enable_go,
  input  wire       frame_busy,
  input  wire       ind_done,
  output reg  [2:0] state_ff,
  output reg        inhibit_ff,
  output reg        ind_req_ff,
  output reg        confirm_ff,
  output reg        flush_ff,
  output reg        rnr_ff
);
  reg defer_ff;
  reg self_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff   <= `RHC_RS_NDEF;
      inhibit_ff <= 1'b1;
      ind_req_ff <= 1'b0;
      confirm_ff <= 1'b0;
      flush_ff   <= 1'b0;
      rnr_ff     <= 1'b0;
      defer_ff   <= 1'b0;
      self_ff    <= 1'b0;
    end else begin
      confirm_ff <= 1'b0;
      flush_ff   <= 1'b0;
      if (define_go) begin
        // new pointers; old fifo contents and deferred indication dropped
        flush_ff   <= 1'b1;
        defer_ff   <= 1'b0;
        rnr_ff     <= 1'b0;
        state_ff   <= def_ready ? `RHC_RS_READY : `RHC_RS_CMPL;
        inhibit_ff <= ~def_ready;
      end else begin
        case (state_ff)
          `RHC_RS_READY, `RHC_RS_CMPL: begin
            if (stop_go) begin
              state_ff   <= `RHC_RS_WAITF;
              inhibit_ff <= 1'b1;
              self_ff    <= self_stop;
            end
          end
          `RHC_RS_WAITF: begin
            // frame or dma move in flight runs to its end
            if (!frame_busy) begin
              state_ff   <= `RHC_RS_WBACK;
              ind_req_ff <= 1'b1;
            end
          end
          `RHC_RS_WBACK: begin
            if (ind_done) begin
              ind_req_ff <= 1'b0;
              state_ff   <= `RHC_RS_STOPPED;
              if (self_ff) begin
                rnr_ff   <= 1'b1;
                defer_ff <= 1'b1;
              end else begin
                confirm_ff <= 1'b1;
              end
            end
          end
          `RHC_RS_STOPPED: begin
            // fifo kept; resume from where it was left
            if (enable_go) begin
              state_ff   <= `RHC_RS_READY;
              inhibit_ff <= 1'b0;
              confirm_ff <= defer_ff;
              defer_ff   <= 1'b0;
              rnr_ff     <= 1'b0;
            end else if (stop_go) begin
              confirm_ff <= 1'b1;
            end
          end
          `RHC_RS_NDEF: begin
            if (stop_go)
              confirm_ff <= 1'b1;
          end
          default: begin
            state_ff <= `RHC_RS_NDEF;
          end
        endcase
      end
    end
  end
endmodule

// [design/rhc_ring_setup.v]
// Purpose: ring setup command handler with an AHB-Lite register slave
// Assumes: commands from host register pair or from a transmit ring fetch
// Notes:   zero wait state slave, always OKAY
// Overview of operation
// - setup command accepted from host or ring
// - decode destination setup, ready and ring fields
// - ready flag sets destination ready, else not
// - pointer fields split into low and high
// - ring pointers wrap inside max length region
// - decode local start command, rings 0-5
// - local start address high and low fields
// - local address wraps inside configured length
// - decode stop ring command, rings 0-5
// - current frame or dma move completes
// - no new frames after stop
// - write back indications, then confirm stop
// - stopped ring keeps fifo, resumes later
// - redefine loads pointers, discards internal data
// - self stop sets flag, defers indication
// - local/indication setting meaning for define
// - define waits for stopped, complete, undefined
`timescale 1ns/1ps
`include "rhc_consts.vh"
module rhc_ring_setup #(
  parameter NRING = 6,
  parameter NDEST = 8
) (
  input  wire              hclk,
  input  wire              hresetn,
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  input  wire              ring_cmd_valid,
  input  wire [63:0]       ring_cmd_data,
  input  wire [2:0]        ring_cmd_src,
  output reg               ring_cmd_ready,
  input  wire [NRING-1:0]  frame_busy,
  input  wire [NRING-1:0]  ind_done,
  input  wire [NRING-1:0]  ring_rd_adv,
  input  wire [NRING-1:0]  lm_adv,
  output wire [NRING-1:0]  ring_inhibit,
  output wire [NRING-1:0]  ind_wb_req,
  output wire [NRING-1:0]  stop_confirm,
  output wire [NRING-1:0]  ring_flush,
  output reg  [NDEST-1:0]  dest_ready
);
  localparam ST_IDLE = 2'd0;
  localparam ST_EXEC = 2'd1;
  localparam ST_DEFW = 2'd2;

  // bus slave state
  reg              wr_pend_ff;
  reg [7:0]        wr_addr_ff;
  reg [31:0]       cmd_lo_ff;
  reg [63:0]       host_cmd_ff;
  reg              host_pend_ff;
  reg              err_ff;
  reg [31:0]       rml_ff;
  reg [17:0]       lml_ff;
  reg [2:0]        sel_ff;
  // execution state
  reg [1:0]        st_ff;
  reg [63:0]       cmd_ff;
  reg [2:0]        src_ff;
  reg              from_ring_ff;
  reg [31:0]       rd_ptr_ff [0:NDEST-1];
  reg [31:0]       wr_ptr_ff [0:NDEST-1];
  reg [31:0]       lm_addr_ff [0:NRING-1];
  reg [NRING-1:0]  define_go;
  reg [NRING-1:0]  stop_go;
  reg [NRING-1:0]  enable_go;
  reg              self_stop;
  reg              def_rdy_ff;

  wire [2:0]       kind;
  wire [2:0]       ring;
  wire             rdy;
  wire [1:0]       li;
  wire [31:0]      dec_rd;
  wire [31:0]      dec_wr;
  wire [3*NRING-1:0] ring_state;
  wire [NRING-1:0] ring_not_ready_flag;

  wire        a_valid = hsel & htrans[1] & hready;
  wire [7:0]  a_ofs   = haddr[7:0];
  wire        host_load = wr_pend_ff & (wr_addr_ff == `RHC_OFS_CMD_HI);
  wire        own_ring  = from_ring_ff & (ring == src_ff);
  wire        src_ok    = (ring <= `RHC_LAST_SRC) & ~own_ring;
  wire [2:0]  tgt_state = ring_state[ring*3 +: 3];
  wire        def_free  = (tgt_state == `RHC_RS_NDEF) | (tgt_state == `RHC_RS_CMPL)
                          | (tgt_state == `RHC_RS_STOPPED);
  wire        li_bad    = (li == `RHC_LI_INVALID)
                          | ((li == `RHC_LI_XFER) & (ring > `RHC_LAST_TX));
  wire        exec_err  = (st_ff == ST_EXEC) &
                          ((kind == `RHC_K_NONE)
                           | ((kind == `RHC_K_DEST) & ((ring == 3'd4) | (ring == 3'd5)
                                                       | own_ring))
                           // stop may name its own ring: that is a self stop
                           | ((kind == `RHC_K_STOP) & (ring > `RHC_LAST_SRC))
                           | ((kind == `RHC_K_LMSA) & ~src_ok)
                           | ((kind == `RHC_K_DEFINE) & ~src_ok)
                           | ((kind == `RHC_K_DEFINE) & li_bad));
  wire        take_host = (st_ff == ST_IDLE) & host_pend_ff;
  wire        take_ring = (st_ff == ST_IDLE) & ~host_pend_ff & ring_cmd_valid & ring_cmd_ready;
  wire        ovr_err   = host_load & host_pend_ff;

  rhc_cmd_decode u_dec (
    .cmd    (cmd_ff),
    .kind   (kind),
    .ring   (ring),
    .rdy    (rdy),
    .li     (li),
    .rd_ptr (dec_rd),
    .wr_ptr (dec_wr)
  );

  // ring length 8 << code bytes, local length 8K << code bytes
  function [31:0] wrap_step;
    input [31:0] p;
    input [31:0] len;
    reg   [31:0] m;
    begin
      m = len - 32'h0000_0001;
      wrap_step = (p & ~m) | ((p + `RHC_STEP) & m);
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < NRING; g = g + 1) begin : g_ring
      rhc_ring_ctl u_ctl (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .define_go  (define_go[g]),
        .def_ready  (def_rdy_ff),
        .stop_go    (stop_go[g]),
        .self_stop  (self_stop),
        .enable_go  (enable_go[g]),
        .frame_busy (frame_busy[g]),
        .ind_done   (ind_done[g]),
        .state_ff   (ring_state[3*g +: 3]),
        .inhibit_ff (ring_inhibit[g]),
        .ind_req_ff (ind_wb_req[g]),
        .confirm_ff (stop_confirm[g]),
        .flush_ff   (ring_flush[g]),
        .rnr_ff     (ring_not_ready_flag[g])
      );
    end
  endgenerate

  // bus slave: zero wait states, every answer OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      hrdata       <= 32'h0000_0000;
      cmd_lo_ff    <= 32'h0000_0000;
      host_cmd_ff  <= 64'h0000_0000_0000_0000;
      host_pend_ff <= 1'b0;
      err_ff       <= 1'b0;
      rml_ff       <= 32'h0000_0000;
      lml_ff       <= 18'h00000;
      sel_ff       <= 3'd0;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      wr_pend_ff <= a_valid & hwrite;
      if (a_valid)
        wr_addr_ff <= a_ofs;
      if (a_valid & ~hwrite) begin
        case (a_ofs)
          `RHC_OFS_STATUS: hrdata <= {24'h000000, host_pend_ff, err_ff, ring_not_ready_flag};
          `RHC_OFS_RML:    hrdata <= rml_ff;
          `RHC_OFS_LML:    hrdata <= {14'h0000, lml_ff};
          `RHC_OFS_STATE:  hrdata <= {14'h0000, ring_state};
          `RHC_OFS_DEST:   hrdata <= {24'h000000, dest_ready};
          `RHC_OFS_SEL:    hrdata <= {29'h00000000, sel_ff};
          `RHC_OFS_RDPTR:  hrdata <= rd_ptr_ff[sel_ff];
          `RHC_OFS_WRPTR:  hrdata <= wr_ptr_ff[sel_ff];
          `RHC_OFS_LMADDR: hrdata <= (sel_ff <= `RHC_LAST_SRC) ? lm_addr_ff[sel_ff]
                                                               : 32'h0000_0000;
          default:         hrdata <= 32'h0000_0000;
        endcase
      end
      if (wr_pend_ff) begin
        case (wr_addr_ff)
          `RHC_OFS_CMD_LO: cmd_lo_ff <= hwdata;
          `RHC_OFS_RML:    rml_ff    <= hwdata;
          `RHC_OFS_LML:    lml_ff    <= hwdata[17:0];
          `RHC_OFS_SEL:    sel_ff    <= hwdata[2:0];
          default: ;
        endcase
      end
      // writing the high word issues the command
      if (host_load & ~host_pend_ff) begin
        host_cmd_ff  <= {hwdata, cmd_lo_ff};
        host_pend_ff <= 1'b1;
      end else if (take_host) begin
        host_pend_ff <= 1'b0;
      end
      // sticky error, set wins over a write-one clear
      if (exec_err | ovr_err)
        err_ff <= 1'b1;
      else if (wr_pend_ff & (wr_addr_ff == `RHC_OFS_STATUS) & hwdata[`RHC_ST_ERR])
        err_ff <= 1'b0;
    end
  end

  // command execution
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff          <= ST_IDLE;
      cmd_ff         <= 64'h0000_0000_0000_0000;
      src_ff         <= 3'd0;
      from_ring_ff   <= 1'b0;
      ring_cmd_ready <= 1'b0;
      dest_ready     <= {NDEST{1'b0}};
      define_go      <= {NRING{1'b0}};
      stop_go        <= {NRING{1'b0}};
      enable_go      <= {NRING{1'b0}};
      self_stop      <= 1'b0;
      def_rdy_ff     <= 1'b0;
      for (i = 0; i < NDEST; i = i + 1) begin
        rd_ptr_ff[i] <= 32'h0000_0000;
        wr_ptr_ff[i] <= 32'h0000_0000;
      end
      for (i = 0; i < NRING; i = i + 1)
        lm_addr_ff[i] <= 32'h0000_0000;
    end else begin
      define_go <= {NRING{1'b0}};
      stop_go   <= {NRING{1'b0}};
      enable_go <= {NRING{1'b0}};
      if (wr_pend_ff & (wr_addr_ff == `RHC_OFS_ENABLE))
        enable_go <= hwdata[NRING-1:0];
      ring_cmd_ready <= (st_ff == ST_IDLE) & ~take_ring & ~take_host & ~host_pend_ff
                        & ~host_load;
      case (st_ff)
        ST_IDLE: begin
          if (take_host) begin
            cmd_ff       <= host_cmd_ff;
            from_ring_ff <= 1'b0;
            st_ff        <= ST_EXEC;
          end else if (take_ring) begin
            cmd_ff       <= ring_cmd_data;
            src_ff       <= ring_cmd_src;
            from_ring_ff <= 1'b1;
            st_ff        <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          st_ff <= ST_IDLE;
          if (!exec_err) begin
            case (kind)
              `RHC_K_DEST: begin
                rd_ptr_ff[ring]  <= dec_rd;
                wr_ptr_ff[ring]  <= dec_wr;
                dest_ready[ring] <= rdy;
              end
              `RHC_K_LMSA: lm_addr_ff[ring] <= dec_wr;
              `RHC_K_STOP: begin
                stop_go[ring] <= 1'b1;
                self_stop     <= own_ring;
              end
              `RHC_K_DEFINE: st_ff <= ST_DEFW;
              default: ;
            endcase
          end
        end
        ST_DEFW: begin
          // held until the ring may be redefined
          if (def_free) begin
            define_go[ring] <= 1'b1;
            def_rdy_ff      <= rdy;
            rd_ptr_ff[ring] <= dec_rd;
            wr_ptr_ff[ring] <= dec_wr;
            st_ff           <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
      for (i = 0; i < NRING; i = i + 1) begin
        if (ring_rd_adv[i] & ~(define_go[i]))
          rd_ptr_ff[i] <= wrap_step(rd_ptr_ff[i],
                                    `RHC_RING_BASE << rml_ff[4*i +: 4]);
        if (lm_adv[i])
          lm_addr_ff[i] <= wrap_step(lm_addr_ff[i],
                                     `RHC_LM_BASE << lml_ff[3*i +: 3]);
      end
    end
  end
endmodule

// [test/rhc_ring_setup_monitor.sv]
// Purpose: port checker for the ring setup command handler
// Assumes: bound to every rhc_ring_setup instance
// Notes:   per ring checks sit in a generate loop
`timescale 1ns/1ps
module rhc_ring_setup_monitor #(
  parameter NRING = 6,
  parameter NDEST = 8
) (
  input wire             hclk,
  input wire             hresetn,
  input wire             hreadyout,
  input wire             hresp,
  input wire             ring_cmd_valid,
  input wire             ring_cmd_ready,
  input wire [NRING-1:0] frame_busy,
  input wire [NRING-1:0] ind_done,
  input wire [NRING-1:0] ind_wb_req,
  input wire [NRING-1:0] ring_inhibit,
  input wire [NRING-1:0] stop_confirm,
  input wire [NRING-1:0] ring_flush,
  input wire [NDEST-1:0] dest_ready
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence seq_taken;
    ring_cmd_valid && ring_cmd_ready;
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("register slave stalled or answered an error");
  AST_CMD_GAP: assert property (seq_taken |=> !ring_cmd_ready [*2])
    else $error("ring command ready back too early");
  genvar i;
  generate
    for (i = 0; i < NRING; i = i + 1) begin : g_ring
      sequence seq_wb_open;
        ind_wb_req[i] && !ind_done[i];
      endsequence
      sequence seq_wb_done;
        ind_wb_req[i] && ind_done[i];
      endsequence
      AST_WB_AFTER_FRAME: assert property ($rose(ind_wb_req[i]) |-> !$past(frame_busy[i]))
        else $error("write-back asked while a frame was in flight");
      AST_WB_INHIBIT: assert property (ind_wb_req[i] |-> ring_inhibit[i])
        else $error("ring not inhibited during stop write-back");
      AST_WB_HOLD: assert property (seq_wb_open |=> ind_wb_req[i])
        else $error("write-back request dropped before done");
      AST_WB_CLOSE: assert property (seq_wb_done |=> !ind_wb_req[i])
        else $error("write-back request held after done");
      AST_CONFIRM_PULSE: assert property (stop_confirm[i] |=> !stop_confirm[i])
        else $error("stop confirm longer than one cycle");
      AST_FLUSH_PULSE: assert property (ring_flush[i] |=> !ring_flush[i])
        else $error("flush longer than one cycle");
    end
  endgenerate
endmodule
bind rhc_ring_setup rhc_ring_setup_monitor #(.NRING(NRING), .NDEST(NDEST)) u_rhc_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .ring_cmd_valid(ring_cmd_valid), .ring_cmd_ready(ring_cmd_ready),
  .frame_busy(frame_busy), .ind_done(ind_done), .ind_wb_req(ind_wb_req),
  .ring_inhibit(ring_inhibit), .stop_confirm(stop_confirm), .ring_flush(ring_flush),
  .dest_ready(dest_ready));

// [test/rhc_ring_side_model.sv]
// Purpose: transmit side of each ring: frames in flight, indication write-back
// Assumes: bench decides when a frame is in flight and how slow write-back is
// Notes:   done is a one-cycle pulse; never answers an absent request
`timescale 1ns/1ps
module rhc_ring_side_model #(
  parameter NRING = 6
) (
  input  wire             hclk,
  input  wire             hresetn,
  input  wire [NRING-1:0] hold_busy,
  input  wire [NRING-1:0] slow,
  input  wire [NRING-1:0] ind_wb_req,
  output reg  [NRING-1:0] frame_busy,
  output reg  [NRING-1:0] ind_done
);
  reg [2:0] cnt_ff [0:NRING-1];
  integer i;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_busy <= {NRING{1'b0}};
      ind_done   <= {NRING{1'b0}};
      for (i = 0; i < NRING; i = i + 1) cnt_ff[i] <= 3'h0;
    end else begin
      for (i = 0; i < NRING; i = i + 1) begin
        frame_busy[i] <= hold_busy[i];
        if (ind_done[i] || !ind_wb_req[i]) begin
          ind_done[i] <= 1'b0;
          cnt_ff[i]   <= 3'h0;
        end else if (cnt_ff[i] == (slow[i] ? 3'h5 : 3'h0)) begin
          ind_done[i] <= 1'b1;
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 3'h1;
        end
      end
    end
  end
endmodule

// [test/rhc_ring_setup_tb_top.sv]
// Purpose: directed bench for the ring setup command handler
// Assumes: zero wait state slave; host and ring stream commands
// Notes:   waits are bounded by the cycle ceiling only
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks = n_checks + 1; if ((got) !== (ex)) begin \
  n_errors = n_errors + 1; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module rhc_ring_setup_tb_top;
  reg         hclk, hresetn, hsel, hwrite, ring_cmd_valid;
  reg  [31:0] haddr, hwdata, rd;
  reg  [1:0]  htrans;
  reg  [2:0]  hsize, ring_cmd_src;
  reg  [63:0] ring_cmd_data;
  reg  [5:0]  ring_rd_adv, lm_adv, hold_busy, slow;
  wire        hready, hreadyout, hresp, ring_cmd_ready;
  wire [31:0] hrdata;
  wire [5:0]  frame_busy, ind_done, ring_inhibit, ind_wb_req, stop_confirm, ring_flush;
  wire [7:0]  dest_ready;
  integer     n_errors = 0, n_checks = 0, cyc = 0, n_flush = 0, k;
  integer     n_conf [0:5];
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  rhc_ring_setup u_rhc_ring_setup (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ring_cmd_valid(ring_cmd_valid),
    .ring_cmd_data(ring_cmd_data), .ring_cmd_src(ring_cmd_src), .ring_cmd_ready(ring_cmd_ready),
    .frame_busy(frame_busy), .ind_done(ind_done), .ring_rd_adv(ring_rd_adv), .lm_adv(lm_adv),
    .ring_inhibit(ring_inhibit), .ind_wb_req(ind_wb_req), .stop_confirm(stop_confirm),
    .ring_flush(ring_flush), .dest_ready(dest_ready));
  rhc_ring_side_model u_rhc_ring_side_model (.hclk(hclk), .hresetn(hresetn),
    .hold_busy(hold_busy), .slow(slow), .ind_wb_req(ind_wb_req), .frame_busy(frame_busy),
    .ind_done(ind_done));
  always @(posedge hclk) begin
    cyc = cyc + 1;
    for (k = 0; k < 6; k = k + 1) if (stop_confirm[k] === 1'b1) n_conf[k] = n_conf[k] + 1;
    if (ring_flush[0] === 1'b1) n_flush = n_flush + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task ahb(input w, input [31:0] a, input [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00; hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task chk_rd(input [31:0] a, input [31:0] ex, input string nm);
    ahb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask
  task host_wait;
    do ahb(1'b0, 32'h08, 32'h0); while (rd[7] !== 1'b0);
  endtask
  task host_go(input [63:0] c);
    ahb(1'b1, 32'h00, c[31:0]);
    ahb(1'b1, 32'h04, c[63:32]);
  endtask
  task host_cmd(input [63:0] c);
    host_go(c);
    host_wait;
  endtask
  task wait_state(input integer r, input [2:0] s);
    do ahb(1'b0, 32'h14, 32'h0); while (rd[3*r +: 3] !== s);
  endtask
  task ring_send(input [63:0] c, input [2:0] src);
    ring_cmd_valid <= 1'b1; ring_cmd_data <= c; ring_cmd_src <= src;
    @(posedge hclk);
    while (ring_cmd_ready !== 1'b1) @(posedge hclk);
    ring_cmd_valid <= 1'b0;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    for (k = 0; k < 6; k = k + 1) n_conf[k] = 0;
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
    htrans = 2'b00; hsize = 3'h2; ring_cmd_valid = 1'b0; ring_cmd_data = 64'h0;
    ring_cmd_src = 3'h0; ring_rd_adv = 6'h00; lm_adv = 6'h00; hold_busy = 6'h00; slow = 6'h00;
    repeat (5) @(posedge hclk);
    `CHK("inhibit", 6'h3F, ring_inhibit)
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    `CHK("cmd ready", 1'b1, ring_cmd_ready)
    chk_rd(32'h3C, 32'h0, "unmapped");
    $display("test reset done");
    host_cmd(64'hBE12_0000_0000_0000);
    `CHK("dest not ready", 8'h00, dest_ready)
    host_cmd(64'hBE1E_FF80_3445_4FF8);
    `CHK("dest ready", 8'h40, dest_ready)
    ahb(1'b1, 32'h1C, 32'h6);
    chk_rd(32'h20, 32'h3445_FF80, "dest rd ptr");
    chk_rd(32'h24, 32'h3445_4FF8, "dest wr ptr");
    chk_rd(32'h08, 32'h0, "status clean");
    $display("test dest done");
    host_cmd(64'hBE14_0000_0000_0000);
    chk_rd(32'h08, 32'h40, "bad dest err");
    `CHK("dest kept", 8'h40, dest_ready)
    ahb(1'b1, 32'h08, 32'h40);
    host_cmd(64'hBE26_0000_0000_0000);
    chk_rd(32'h08, 32'h40, "bad stop err");
    ahb(1'b1, 32'h08, 32'h40);
    chk_rd(32'h08, 32'h0, "err cleared");
    $display("test refuse done");
    ahb(1'b1, 32'h10, 32'h10);
    host_cmd(64'hBE19_0000_9454_7FF8);
    ahb(1'b1, 32'h1C, 32'h1);
    chk_rd(32'h28, 32'h9454_7FF8, "local start");
    lm_adv <= 6'h02;
    @(posedge hclk);
    lm_adv <= 6'h00;
    chk_rd(32'h28, 32'h9454_0000, "local wrap");
    $display("test local done");
    ahb(1'b1, 32'h0C, 32'h4);
    host_cmd(64'hBE28_4FF8_3445_4FF8);
    chk_rd(32'h14, 32'h1, "ring0 ready");
    ring_rd_adv <= 6'h01;
    @(posedge hclk);
    ring_rd_adv <= 6'h00;
    ahb(1'b1, 32'h1C, 32'h0);
    chk_rd(32'h20, 32'h3445_4F80, "rd wrap");
    chk_rd(32'h24, 32'h3445_4FF8, "wr kept");
    $display("test define done");
    hold_busy <= 6'h01;
    host_go(64'hBE20_0000_0000_0000);
    wait_state(0, 3'h3);
    repeat (4) @(posedge hclk);
    `CHK("no wb in frame", 1'b0, ind_wb_req[0])
    `CHK("stop inhibit", 1'b1, ring_inhibit[0])
    hold_busy <= 6'h00;
    wait_state(0, 3'h5);
    host_wait;
    `CHK("confirm", 1, n_conf[0])
    ahb(1'b1, 32'h2C, 32'h1);
    repeat (2) @(posedge hclk);
    `CHK("re-enable", 1'b0, ring_inhibit[0])
    $display("test stop done");
    hold_busy <= 6'h01;
    slow <= 6'h01;
    host_go(64'hBE20_0000_0000_0000);
    wait_state(0, 3'h3);
    ring_send(64'hBE28_1000_1234_2000, 3'h3);
    repeat (6) @(posedge hclk);
    chk_rd(32'h14, 32'h3, "define held");
    `CHK("no flush yet", 1, n_flush)
    hold_busy <= 6'h00;
    wait_state(0, 3'h1);
    host_wait;
    `CHK("flush", 2, n_flush)
    `CHK("confirm2", 2, n_conf[0])
    chk_rd(32'h20, 32'h1234_1000, "new rd ptr");
    chk_rd(32'h24, 32'h1234_2000, "new wr ptr");
    $display("test redefine done");
    host_cmd(64'hBE2A_0000_0000_0000);
    ring_send(64'hBE22_0000_0000_0000, 3'h2);
    wait_state(2, 3'h5);
    chk_rd(32'h08, 32'h4, "self stop flag");
    `CHK("deferred", 0, n_conf[2])
    ahb(1'b1, 32'h2C, 32'h4);
    repeat (3) @(posedge hclk);
    `CHK("late confirm", 1, n_conf[2])
    $display("test self stop done");
    host_cmd(64'hBE69_0000_0000_0000);
    host_cmd(64'hFE6C_0000_0000_0000);
    chk_rd(32'h14, 32'h49, "local define");
    chk_rd(32'h08, 32'h40, "xfer on rx err");
    $display("test local define done");
    report_and_stop;
  end
endmodule
